// ==== hdl/tsw_pkg.sv ====
// Purpose: Shared constants and types of the two-wire serial shift port.
// Assumes: 250 MHz system clock, 8-bit register port with a 4-bit address.
// Notes: Offsets, field positions, reset values and timing counts live here only.

package tsw_pkg;

  // ************************************************************
  // Register port geometry and offsets
  // ************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_SHIFT = 4'h1;
  localparam logic [3:0] REG_COUNT = 4'h2;
  localparam logic [3:0] REG_IRQ_STAT = 4'h3;
  localparam logic [3:0] REG_IRQ_CLR = 4'h4;
  localparam logic [3:0] REG_IRQ_EN = 4'h5;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int CTRL_MASTER = 0;
  localparam int CTRL_TX = 1;
  localparam int CTRL_NWT = 2;
  localparam int CTRL_ACK = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ACK = 1;
  localparam int IRQ_W = 2;
  localparam logic [7:0] SHIFT_RST = 8'h00;
  localparam logic CTRL_BIT_RST = 1'b0;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  // ************************************************************
  // Bit counter marks
  // ************************************************************
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_LAST_DATA = 4'h7;
  localparam logic [3:0] CNT_ACK_OUT = 4'h8;
  localparam logic [3:0] CNT_DONE = 4'h9;

  // ************************************************************
  // Timing of the internally generated shift clock
  // ************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W = 11;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCL_HALF_CYC - 1);

  // ************************************************************
  // Transfer phase
  // ************************************************************
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_DATA = 2'b01,
    PH_ACK = 2'b10
  } tsw_phase_type;

endpackage

// ==== hdl/tsw_pins_if.sv ====
// Purpose: Carries the sampled line levels and clock-line edges to the core.
// Assumes: All members are driven in the system clock domain.
// Notes: Edges are one-cycle pulses; rise and fall never coincide.
`timescale 1ns/100ps

interface tsw_pins_if;
  logic scl_lvl;
  logic sda_lvl;
  logic scl_rise;
  logic scl_fall;
  modport sense (output scl_lvl, output sda_lvl, output scl_rise, output scl_fall);
  modport core (input scl_lvl, input sda_lvl, input scl_rise, input scl_fall);
endinterface

// ==== hdl/tsw_line_sense.sv ====
// Purpose: Brings both bus lines into the clock domain and finds clock-line edges.
// Assumes: Lines change slowly against the 4 ns system clock.
// Notes: The first stage of each synchroniser feeds only the second stage.
`timescale 1ns/100ps

module tsw_line_sense (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Raw line levels
  input wire logic scl_in,
  input wire logic sda_in,
  // Cleaned levels and edges
  tsw_pins_if.sense pins
);
  import tsw_pkg::*;

  logic [1:0] raw;
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] last_q;

  // Index 0 is the clock line, index 1 the data line.
  assign raw = {sda_in, scl_in};

  // ************************************************************
  // Two-stage synchronisers plus a history stage
  // ************************************************************
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_line
      // Lines idle high, so reset to the released level to avoid a false edge.
      always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
          meta_q[i] <= 1'b1;
          sync_q[i] <= 1'b1;
          last_q[i] <= 1'b1;
        end else begin
          meta_q[i] <= raw[i];
          sync_q[i] <= meta_q[i];
          last_q[i] <= sync_q[i];
        end
      end
    end
  endgenerate

  // Edges compare the settled stage with its history only.
  assign pins.scl_lvl = sync_q[0];
  assign pins.sda_lvl = sync_q[1];
  assign pins.scl_rise = sync_q[0] & ~last_q[0];
  assign pins.scl_fall = ~sync_q[0] & last_q[0];

endmodule

// ==== hdl/tsw_serial_core.sv ====
// Purpose: Shift, wait and acknowledge engine of a two-wire serial port.
// Assumes: Lines are open drain with external pull-ups; software writes
//          control and shift data only while the port waits.
// Notes: Register port answers reads one cycle later; one level interrupt.
`timescale 1ns/100ps

// How it works
// [R1] Transmit shifts MSB out on falling edges
// [R2] Every mode samples data in at LSB on rise
// [R3] Wait state pulls clock low, data released
// [R4] No-wait releases clock, follows external edges
// [R5] Hardware clears no-wait when step completes
// [R6] Receiver drives acknowledge flag after count eight
// [R7] Transmitter captures acknowledge when count becomes nine
// [R8] Bit counter counts every rising clock edge
// [R9] Select bits choose role and direction
// [R10] Master drives generated clock, slave follows
// [R11] Lines only ever driven low, open drain
module tsw_serial_core (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Register port
  input wire logic [tsw_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [tsw_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [tsw_pkg::DATA_W-1:0] reg_rdata_out,
  // Clock line
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  // Data line
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Interrupt
  output logic irq_out
);
  import tsw_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  tsw_pins_if pins ();

  tsw_phase_type phase_q, phase_d;
  logic master_q, master_d;
  logic tx_q, tx_d;
  logic ack_q, ack_d;
  logic [7:0] sr_q, sr_d;
  logic [3:0] cnt_q, cnt_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic gen_q, gen_d;
  logic sda_oe_q, sda_oe_d;
  logic scl_oe_q, scl_oe_d;
  logic [IRQ_W-1:0] stat_q, stat_d;
  logic [IRQ_W-1:0] en_q, en_d;
  logic irq_q, irq_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic active;
  logic active_d;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;

  // Address decode shared by the write and read paths.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [3:0] off);
    reg_hit = (addr == off);
  endfunction

  // ************************************************************
  // Line sensing
  // ************************************************************
  tsw_line_sense u_sense (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .pins(pins.sense)
  );

  // ************************************************************
  // Next-state logic
  // ************************************************************
  // One process covers the engine and the registers, because software
  // writes and line events touch the same state.
  always_comb begin
    phase_d = phase_q;
    master_d = master_q;
    tx_d = tx_q;
    ack_d = ack_q;
    sr_d = sr_q;
    cnt_d = cnt_q;
    div_d = div_q;
    gen_d = gen_q;
    sda_oe_d = sda_oe_q;
    en_d = en_q;
    rdata_d = '0;
    ev = '0;
    clr = '0;
    active = (phase_q != PH_IDLE);

    // [R9] role and direction select
    // Control and shift data writes take effect only while the port waits.
    if (reg_wr_in && reg_hit(reg_addr_in, REG_CTRL) && !active) begin
      master_d = reg_wdata_in[CTRL_MASTER];
      tx_d = reg_wdata_in[CTRL_TX];
      ack_d = reg_wdata_in[CTRL_ACK];
      if (reg_wdata_in[CTRL_NWT]) begin
        phase_d = PH_DATA;
        cnt_d = CNT_ZERO;
        // [R1] first bit presented
        sda_oe_d = reg_wdata_in[CTRL_TX] & ~sr_q[7];
      end
    end
    if (reg_wr_in && reg_hit(reg_addr_in, REG_SHIFT) && !active) begin
      sr_d = reg_wdata_in;
    end
    if (reg_wr_in && reg_hit(reg_addr_in, REG_IRQ_CLR)) begin
      clr = reg_wdata_in[IRQ_W-1:0];
    end
    if (reg_wr_in && reg_hit(reg_addr_in, REG_IRQ_EN)) begin
      en_d = reg_wdata_in[IRQ_W-1:0];
    end

    // [R4] follow external edges
    if (active && pins.scl_rise) begin
      // [R2] sample at LSB
      sr_d = {sr_q[6:0], pins.sda_lvl};
      // [R8] count rising edges
      cnt_d = cnt_q + 4'h1;
      if (cnt_q == CNT_LAST_DATA) begin
        phase_d = PH_ACK;
      end
      // [R7] capture acknowledge
      if (tx_q && cnt_q == CNT_ACK_OUT) begin
        ack_d = pins.sda_lvl;
        ev[IRQ_ACK] = 1'b1;
      end
    end else if (active && pins.scl_fall) begin
      if (cnt_q < CNT_ACK_OUT) begin
        // [R1] next bit from MSB
        sda_oe_d = tx_q & ~sr_q[7];
      end else if (cnt_q == CNT_ACK_OUT) begin
        // [R6] receiver drives acknowledge
        sda_oe_d = ~tx_q & ~ack_q;
      end else begin
        // [R5] step done, back to wait
        phase_d = PH_IDLE;
        cnt_d = CNT_ZERO;
        sda_oe_d = 1'b0;
        ev[IRQ_DONE] = 1'b1;
      end
    end

    // Internal shift clock; a peer holding the line low stretches the high phase.
    if (!master_q || !active) begin
      div_d = '0;
      gen_d = 1'b0;
    end else if (div_q == DIV_LAST) begin
      div_d = '0;
      if (!gen_q) begin
        gen_d = 1'b1;
      end else if (pins.scl_lvl) begin
        gen_d = 1'b0;
      end
    end else begin
      div_d = div_q + DIV_W'(1);
    end

    active_d = (phase_d != PH_IDLE);
    // [R3] wait holds clock low
    if (!active_d) begin
      sda_oe_d = 1'b0;
      scl_oe_d = 1'b1;
    end else begin
      // [R10] master drives clock
      scl_oe_d = master_d & ~gen_d;
    end

    // Hardware set wins over a clear in the same cycle.
    stat_d = (stat_q & ~clr) | ev;
    irq_d = |(stat_d & en_d);

    // Read data stands for exactly one cycle after the strobe.
    if (reg_rd_in) begin
      if (reg_hit(reg_addr_in, REG_CTRL)) begin
        rdata_d[CTRL_MASTER] = master_q;
        rdata_d[CTRL_TX] = tx_q;
        rdata_d[CTRL_NWT] = active;
        rdata_d[CTRL_ACK] = ack_q;
      end else if (reg_hit(reg_addr_in, REG_SHIFT)) begin
        rdata_d = sr_q;
      end else if (reg_hit(reg_addr_in, REG_COUNT)) begin
        rdata_d[3:0] = cnt_q;
      end else if (reg_hit(reg_addr_in, REG_IRQ_STAT)) begin
        rdata_d[IRQ_W-1:0] = stat_q;
      end else if (reg_hit(reg_addr_in, REG_IRQ_EN)) begin
        rdata_d[IRQ_W-1:0] = en_q;
      end
    end
  end

  // ************************************************************
  // State registers
  // ************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      phase_q <= PH_IDLE;
      master_q <= CTRL_BIT_RST;
      tx_q <= CTRL_BIT_RST;
      ack_q <= CTRL_BIT_RST;
      sr_q <= SHIFT_RST;
      cnt_q <= CNT_ZERO;
      div_q <= '0;
      gen_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b1;
      stat_q <= IRQ_RST;
      en_q <= IRQ_RST;
      irq_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      phase_q <= phase_d;
      master_q <= master_d;
      tx_q <= tx_d;
      ack_q <= ack_d;
      sr_q <= sr_d;
      cnt_q <= cnt_d;
      div_q <= div_d;
      gen_q <= gen_d;
      sda_oe_q <= sda_oe_d;
      scl_oe_q <= scl_oe_d;
      stat_q <= stat_d;
      en_q <= en_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // [R11] drive only low levels
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = scl_oe_q;
  assign sda_oe_out = sda_oe_q;
  assign irq_out = irq_q;
  assign reg_rdata_out = rdata_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  chk_wait_scl_low: assert property ( // [R3]
    (phase_q == PH_IDLE) |-> (scl_oe_out && !sda_oe_out))
    else $error("wait state does not hold clock low with data released");

  chk_slave_scl_free: assert property ( // [R10]
    (phase_q != PH_IDLE && !master_q) |-> !scl_oe_out)
    else $error("slave drives the clock line while not waiting");

  chk_rise_count: assert property ( // [R8]
    (phase_q != PH_IDLE && pins.scl_rise) |=> (cnt_q == $past(cnt_q) + 4'h1))
    else $error("bit counter missed a rising edge");

  chk_rise_shift: assert property ( // [R2]
    (phase_q != PH_IDLE && pins.scl_rise) |=> (sr_q == {$past(sr_q[6:0]), $past(pins.sda_lvl)}))
    else $error("shift register did not take the data line at its low end");

  chk_tx_msb_out: assert property ( // [R1]
    (phase_q != PH_IDLE && tx_q && pins.scl_fall && cnt_q < CNT_ACK_OUT) |=> (sda_oe_out == !$past(sr_q[7])))
    else $error("transmit did not present the top bit after a falling edge");

  chk_ack_drive: assert property ( // [R6]
    (phase_q != PH_IDLE && !tx_q && pins.scl_fall && cnt_q == CNT_ACK_OUT) |=> (sda_oe_out == !ack_q) [*2])
    else $error("receiver did not drive the acknowledge flag");

  chk_ack_capture: assert property ( // [R7]
    (phase_q != PH_IDLE && tx_q && pins.scl_rise && cnt_q == CNT_ACK_OUT) |=> (ack_q == $past(pins.sda_lvl) && stat_q[IRQ_ACK]))
    else $error("transmitter did not capture the acknowledge level");

  chk_step_done: assert property ( // [R5]
    (phase_q != PH_IDLE && pins.scl_fall && cnt_q == CNT_DONE) |=> (phase_q == PH_IDLE && stat_q[IRQ_DONE] && scl_oe_out))
    else $error("step end did not return to the wait state");

  chk_rx_quiet: assert property ( // [R4]
    (phase_q == PH_DATA && !tx_q) |-> !sda_oe_out)
    else $error("receiver drives the data line during data bits");

  chk_irq_level: assert property (
    (|(stat_q & en_q)) == irq_out)
    else $error("interrupt output disagrees with enabled status");

endmodule

// ==== sim/tsw_peer_model.sv ====
// Purpose: Peer on the two-wire bus that clocks and answers the port.
// Assumes: Both lines have pull-ups; the peer clocks at 125 ns only inside frames.
// Notes: Bits of a frame are numbered 1 to 9, the ninth is the acknowledge.
`timescale 1ns/100ps

module tsw_peer_model (
  // Line levels
  input wire logic scl_in,
  input wire logic sda_in,
  // Pull-down enables
  output logic scl_oe_out,
  output logic sda_oe_out
);
  logic [7:0] got_byte;
  logic got_ack;

  // Open drain only.
  // The peer holds the clock low between frames so the port never sees a stray edge.
  initial begin
    scl_oe_out = 1'b1;
    sda_oe_out = 1'b0;
    got_byte = 8'h00;
    got_ack = 1'b0;
  end

  // A 1 in bits releases the data line, a 0 pulls it low.
  task automatic clocks(input int first, input int last, input logic [8:0] bits);
    for (int i = first; i <= last; i++) begin
      #31.2 sda_oe_out = !bits[9-i];
      #31.3 scl_oe_out = 1'b0;
      #31.2 got_ack = sda_in;
      if (i < 9) got_byte = {got_byte[6:0], sda_in};
      #31.3 scl_oe_out = 1'b1;
    end
    #31.2 sda_oe_out = 1'b0;
  endtask

  // Lets the port generate the clock itself.
  task automatic free_clock();
    scl_oe_out = 1'b0;
  endtask
endmodule

// ==== sim/tsw_serial_core_tb_top.sv ====
// Purpose: Self-checking bench of the two-wire serial shift core.
// Assumes: The peer model clocks the bus in slave role; pull-ups on both lines.
// Notes: Master role runs the full generated clock, about 22500 cycles a step; two steps run.
`timescale 1ns/100ps

module tsw_serial_core_tb_top;
  import tsw_pkg::*;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic scl_out, scl_oe_out, sda_out, sda_oe_out, irq_out, p_scl_oe, p_sda_oe;
  logic [7:0] rv;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int n_rise = 0;
  // Wired-and of all pull-downs against the pull-ups.
  wire scl_line = !(scl_oe_out | p_scl_oe);
  wire sda_line = !(sda_oe_out | p_sda_oe);

  always #2 sys_clk_in = !sys_clk_in;

  tsw_serial_core tsw_serial_core_inst (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .scl_in(scl_line), .scl_out(scl_out),
    .scl_oe_out(scl_oe_out), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .irq_out(irq_out));
  tsw_peer_model tsw_peer_model_inst (.scl_in(scl_line), .sda_in(sda_line),
    .scl_oe_out(p_scl_oe), .sda_oe_out(p_sda_oe));

  // Clock-line rises, used to count generated clocks in master role.
  always @(posedge scl_line) begin
    n_rise++;
  end

  // The ceiling is well above the longest expected run.
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 80000) begin
      n_errors++;
      $display("Error at %0t: run did not finish", $time);
      complete_run();
    end
  end

  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  // Read data stand only in the cycle after the read edge.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask

  task automatic t_reset_state();
    chk(8'h01, {7'h00, scl_oe_out});
    chk(8'h00, {7'h00, sda_oe_out});
    chk(8'h00, {6'h00, scl_out, sda_out});
    rd(REG_CTRL, rv);
    chk(8'h00, rv);
    rd(4'hf, rv);
    chk(8'h00, rv);
  endtask

  // Slave transmit, split after five bits to see the count and a refused write.
  task automatic t_slave_tx(input logic [7:0] b, input logic a, input logic en);
    wr(REG_IRQ_CLR, 8'h03);
    wr(REG_IRQ_EN, {7'h00, en});
    wr(REG_SHIFT, b);
    wr(REG_CTRL, 8'h06);
    repeat (2) @(posedge sys_clk_in);
    chk(8'h00, {7'h00, scl_oe_out});
    tsw_peer_model_inst.clocks(1, 5, {8'hff, a});
    rd(REG_COUNT, rv);
    chk(8'h05, rv);
    wr(REG_SHIFT, 8'h00);
    tsw_peer_model_inst.clocks(6, 9, {8'hff, a});
    repeat (8) @(posedge sys_clk_in);
    chk(b, tsw_peer_model_inst.got_byte);
    // The ninth rise shifts the acknowledge level in behind the byte.
    rd(REG_SHIFT, rv);
    chk({b[6:0], a}, rv);
    rd(REG_CTRL, rv);
    chk({4'h0, a, 3'b010}, rv);
    chk(8'h01, {7'h00, scl_oe_out});
    rd(REG_IRQ_STAT, rv);
    chk(8'h03, rv);
    chk({7'h00, en}, {7'h00, irq_out});
    rd(REG_IRQ_EN, rv);
    chk({7'h00, en}, rv);
    wr(REG_IRQ_CLR, 8'h03);
    repeat (3) @(posedge sys_clk_in);
    chk(8'h00, {7'h00, irq_out});
  endtask

  // Slave receive with the acknowledge flag preset.
  task automatic t_slave_rx(input logic [7:0] b, input logic a);
    wr(REG_CTRL, {4'h0, a, 3'b000});
    wr(REG_CTRL, {4'h0, a, 3'b100});
    tsw_peer_model_inst.clocks(1, 9, {b, 1'b1});
    repeat (8) @(posedge sys_clk_in);
    chk({7'h00, a}, {7'h00, tsw_peer_model_inst.got_ack});
    rd(REG_SHIFT, rv);
    chk({b[6:0], a}, rv);
  endtask

  // Master step: the port makes nine clocks itself and reads its own line back.
  // The peer stays released, so the acknowledge level is the port's own flag in receive.
  task automatic t_master(input logic tx, input logic [7:0] b);
    tsw_peer_model_inst.free_clock();
    n_rise = 0;
    wr(REG_SHIFT, b);
    wr(REG_CTRL, {6'h01, tx, 1'b1});
    rv = 8'h04;
    for (int i = 0; i < 100 && rv[2] !== 1'b0; i++) begin
      repeat (500) @(posedge sys_clk_in);
      rd(REG_CTRL, rv);
    end
    chk(8'h09, n_rise[7:0]);
    rd(REG_SHIFT, rv);
    chk({(tx ? b[6:0] : 7'h7f), tx}, rv);
    rd(REG_CTRL, rv);
    chk({4'h0, tx, 1'b0, tx, 1'b1}, rv);
    chk(8'h01, {7'h00, scl_oe_out});
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    t_reset_state();
    t_slave_tx(8'ha5, 1'b0, 1'b1);
    t_slave_tx(8'h5a, 1'b1, 1'b0);
    t_slave_rx(8'h3c, 1'b0);
    t_slave_rx(8'hc3, 1'b1);
    t_master(1'b0, 8'h00);
    t_master(1'b1, 8'h96);
    complete_run();
  end
endmodule
